// *** include/rrs_cfg.svh ***
/*
  Register offsets, field positions, reset values and key codes of the
  round-robin configuration bank.
  Assumes the including file is compiled after rrs_pkg.
*/
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RRS_ADDR_RR_EN 8'h06
`define RRS_ADDR_MASK 8'h07
`define RRS_ADDR_EDGE 8'h09
`define RRS_ADDR_KEY 8'h0B

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RRS_RR_EN_BIT 0
`define RRS_EDGE_BIT 0

// ----------------------------------------------------------------------
// Reset values and key codes
// ----------------------------------------------------------------------
`define RRS_RR_EN_RST 1'b0
`define RRS_EDGE_RST 1'b0
`define RRS_KEY_READ 8'h00
`define RRS_KEY_FIRST 8'hA3
`define RRS_KEY_SECOND 8'h05
`define RRS_RDATA_RST 8'h00

`endif

// *** include/rrs_pkg.sv ***
/*
  Types shared by the round-robin configuration bank.
  Assumes nothing of its surroundings.
*/
package rrs_pkg;

  // Register write request: offset and data
  typedef struct packed
  {
    logic [7:0] addr;
    logic [7:0] data;
  } rrs_wr_s;

  // Control bits that steer the sequencer
  typedef struct packed
  {
    logic rr_en;
    logic edge_rise;
  } rrs_ctrl_s;

  // Reset key detector
  typedef enum logic
  {
    RRS_KEY_IDLE = 1'b0,
    RRS_KEY_ARMED = 1'b1
  } rrs_key_e;

endpackage

// *** rtl/rrs_next_chan.sv ***
/*
  Finds the next included channel above the current one, wrapping to
  the lowest included channel.
  Assumes a purely combinational use; the caller registers the result.
*/
module rrs_next_chan
  import rrs_pkg::*;
#(
  parameter int NUM_CHAN = 8,
  parameter int CW = 3
)
(
  // Inputs
  input wire logic [NUM_CHAN-1:0] i_mask,
  input wire logic [CW-1:0] i_cur,
  // Results
  output logic [CW-1:0] o_next,
  output logic o_any
);

  // ----------------------------------------------------------------------
  // Search
  // ----------------------------------------------------------------------
  // ascending with wrap
  always_comb
  begin
    int idx;
    idx = 0;
    o_next = i_cur;
    o_any = |i_mask;
    // Farthest candidate first so the nearest one wins
    for (int k = NUM_CHAN; k >= 1; k--)
    begin
      idx = (int'(i_cur) + k) % NUM_CHAN;
      if (i_mask[idx])
      begin
        o_next = CW'(idx);
      end
    end
  end

endmodule

// *** rtl/rrs_cfg_bank.sv ***
/*
  Configuration bank of a serially controlled multiplexer: round-robin
  enable, channel include mask, trigger edge choice, software reset key,
  and the channel sequencer that the trigger pin steps.
  Assumes frames are already decoded into single-cycle register
  strobes, and that the trigger pin is synchronous to i_mclk.
*/
`include "rrs_cfg.svh"

module rrs_cfg_bank
  import rrs_pkg::*;
#(
  parameter int NUM_CHAN = 8,
  parameter int CW = $clog2(NUM_CHAN)
)
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Register write port
  input wire logic i_wr_valid,
  input wire rrs_wr_s i_wr,
  // Register read port
  input wire logic i_rd_valid,
  input wire logic [7:0] i_rd_addr,
  output logic [7:0] o_rd_data,
  // Conversion trigger
  input wire logic i_conv_trig,
  // Switch state
  output logic [CW-1:0] o_chan_sel,
  output logic o_rr_active,
  output logic o_soft_reset
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam logic [NUM_CHAN-1:0] MASK_RST = '1;

  rrs_ctrl_s ctrl;
  logic [NUM_CHAN-1:0] chan_mask;
  rrs_key_e key_state;
  rrs_key_e next_key_state;
  logic soft_rst_now;
  logic trig_prev;
  logic trig_rise;
  logic trig_fall;
  logic active_edge;
  logic [CW-1:0] next_chan;
  logic any_incl;
  logic wr_rr_en;
  logic wr_mask;
  logic wr_edge;
  logic wr_key;
  logic [7:0] next_rd_data;

  // ----------------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    wr_rr_en = 1'b0;
    wr_mask = 1'b0;
    wr_edge = 1'b0;
    wr_key = 1'b0;
    // Writes to read-only or unmapped offsets are dropped
    if (!i_wr_valid)
    begin
      wr_key = 1'b0;
    end
    else if (i_wr.addr == `RRS_ADDR_RR_EN)
    begin
      wr_rr_en = 1'b1;
    end
    else if (i_wr.addr == `RRS_ADDR_MASK)
    begin
      wr_mask = 1'b1;
    end
    else if (i_wr.addr == `RRS_ADDR_EDGE)
    begin
      wr_edge = 1'b1;
    end
    else if (i_wr.addr == `RRS_ADDR_KEY)
    begin
      wr_key = 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Software reset key
  // ----------------------------------------------------------------------
  // two-write key detector
  always_comb
  begin
    next_key_state = RRS_KEY_IDLE;
    soft_rst_now = 1'b0;
    case (key_state)
      RRS_KEY_IDLE:
      begin
        if (wr_key && i_wr.data == `RRS_KEY_FIRST)
        begin
          next_key_state = RRS_KEY_ARMED;
        end
      end
      RRS_KEY_ARMED:
      begin
        // any write other than a key half drops the half key; a repeated first half keeps it armed
        if (!i_wr_valid)
        begin
          next_key_state = RRS_KEY_ARMED;
        end
        else if (wr_key && i_wr.data == `RRS_KEY_SECOND)
        begin
          soft_rst_now = 1'b1;
        end
        else if (wr_key && i_wr.data == `RRS_KEY_FIRST)
        begin
          next_key_state = RRS_KEY_ARMED;
        end
      end
      default:
      begin
        next_key_state = RRS_KEY_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      key_state <= RRS_KEY_IDLE;
    end
    else
    begin
      key_state <= next_key_state;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_soft_reset <= 1'b0;
    end
    else
    begin
      o_soft_reset <= soft_rst_now;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // key completion restores defaults
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl.rr_en <= `RRS_RR_EN_RST;
      ctrl.edge_rise <= `RRS_EDGE_RST;
    end
    else if (soft_rst_now)
    begin
      ctrl.rr_en <= `RRS_RR_EN_RST;
      ctrl.edge_rise <= `RRS_EDGE_RST;
    end
    else
    begin
      if (wr_rr_en)
      begin
        ctrl.rr_en <= i_wr.data[`RRS_RR_EN_BIT];
      end
      // edge choice bit, upper bits ignored
      if (wr_edge)
      begin
        ctrl.edge_rise <= i_wr.data[`RRS_EDGE_BIT];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      chan_mask <= MASK_RST;
    end
    else if (soft_rst_now)
    begin
      chan_mask <= MASK_RST;
    end
    else if (wr_mask)
    begin
      // bits above the channel count are not stored
      chan_mask <= i_wr.data[NUM_CHAN-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rd_data = `RRS_RDATA_RST;
    if (i_rd_addr == `RRS_ADDR_RR_EN)
    begin
      next_rd_data = {7'h00, ctrl.rr_en};
    end
    else if (i_rd_addr == `RRS_ADDR_MASK)
    begin
      next_rd_data = 8'(chan_mask);
    end
    else if (i_rd_addr == `RRS_ADDR_EDGE)
    begin
      next_rd_data = {7'h00, ctrl.edge_rise};
    end
    else if (i_rd_addr == `RRS_ADDR_KEY)
    begin
      next_rd_data = `RRS_KEY_READ;
    end
  end

  // Read data holds until the next read strobe
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_rd_data <= `RRS_RDATA_RST;
    end
    else if (i_rd_valid)
    begin
      o_rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger edge and sequencer
  // ----------------------------------------------------------------------
  // A pin high at reset release is seen as a rising edge once
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      trig_prev <= 1'b0;
    end
    else
    begin
      trig_prev <= i_conv_trig;
    end
  end

  assign trig_rise = i_conv_trig && !trig_prev;
  assign trig_fall = !i_conv_trig && trig_prev;
  // edge choice selects the active edge
  assign active_edge = ctrl.edge_rise ? trig_rise : trig_fall;

  rrs_next_chan #(
    .NUM_CHAN(NUM_CHAN),
    .CW(CW)
  ) u_next_chan (
    .i_mask(chan_mask),
    .i_cur(o_chan_sel),
    .o_next(next_chan),
    .o_any(any_incl)
  );

  // mask bit index equals channel index
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_chan_sel <= '0;
    end
    else if (soft_rst_now)
    begin
      o_chan_sel <= '0;
    end
    // edges step only in round-robin mode
    else if (ctrl.rr_en && active_edge && any_incl)
    begin
      o_chan_sel <= next_chan;
    end
  end

  assign o_rr_active = ctrl.rr_en;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_key_first;
    i_wr_valid && i_wr.addr == `RRS_ADDR_KEY
      && i_wr.data == `RRS_KEY_FIRST;
  endsequence

  sequence s_key_second;
    i_wr_valid && i_wr.addr == `RRS_ADDR_KEY
      && i_wr.data == `RRS_KEY_SECOND;
  endsequence

  sequence s_key_broken;
    i_wr_valid && !(i_wr.addr == `RRS_ADDR_KEY
      && (i_wr.data == `RRS_KEY_SECOND || i_wr.data == `RRS_KEY_FIRST));
  endsequence

  // Key halves are separated by an idle bus cycle, as the host writes them
  a_key_sequence_resets: assert property (
    s_key_first ##1 !i_wr_valid ##1 s_key_second |=> o_soft_reset)
    else $error("Key sequence did not reset");

  a_broken_key_ignored: assert property (
    s_key_first ##1 !i_wr_valid ##1 s_key_broken
      |=> !o_soft_reset ##1 !o_soft_reset)
    else $error("Broken key still reset");

  a_reset_needs_key: assert property (
    o_soft_reset |-> $past(key_state) == RRS_KEY_ARMED)
    else $error("Reset without armed key");

  a_soft_reset_defaults: assert property (
    o_soft_reset |-> chan_mask == MASK_RST && !ctrl.rr_en
      && !ctrl.edge_rise && o_chan_sel == '0)
    else $error("Registers not at defaults after reset");

  a_key_reads_zero: assert property (
    i_rd_valid && i_rd_addr == `RRS_ADDR_KEY |=> o_rd_data == 8'h00)
    else $error("Key register read nonzero");

  a_mask_upper_zero: assert property (
    i_rd_valid && i_rd_addr == `RRS_ADDR_MASK
      |=> (o_rd_data >> NUM_CHAN) == 8'h00
      && o_rd_data[NUM_CHAN-1:0] == $past(chan_mask))
    else $error("Mask read wrong");

  a_edge_readback: assert property (
    i_rd_valid && i_rd_addr == `RRS_ADDR_EDGE
      |=> o_rd_data == {7'h00, $past(ctrl.edge_rise)})
    else $error("Edge choice read wrong");

  a_idle_edges_ignored: assert property (
    !ctrl.rr_en && !soft_rst_now |=> $stable(o_chan_sel))
    else $error("Channel moved outside round-robin mode");

  a_edge_advances: assert property (
    ctrl.rr_en && !soft_rst_now && any_incl
      && (ctrl.edge_rise ? (i_conv_trig && !trig_prev)
                         : (!i_conv_trig && trig_prev))
      |=> o_chan_sel == $past(next_chan))
    else $error("Active edge did not advance");

  a_next_included: assert property (
    any_incl |-> chan_mask[next_chan])
    else $error("Next channel not included");

  a_mode_write: assert property (
    i_wr_valid && i_wr.addr == `RRS_ADDR_RR_EN && !soft_rst_now
      |=> o_rr_active == $past(i_wr.data[0]))
    else $error("Mode enable not written");

endmodule

// *** verif/rrs_host_model.sv ***
/*
  Host and trigger source model: byte writes, reads, trigger levels.
  Assumes the bank samples on the rising edge of i_mclk.
*/
`include "rrs_cfg.svh"

module rrs_host_model
  import rrs_pkg::*;
(
  // Clock
  input wire logic i_mclk,
  // Register access
  output logic o_wr_valid,
  output rrs_wr_s o_wr,
  output logic o_rd_valid,
  output logic [7:0] o_rd_addr,
  // Trigger
  output logic o_conv_trig
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_wr_valid = 1'b0;
    o_wr = 16'h5AA5;
    o_rd_valid = 1'b0;
    o_rd_addr = 8'hC3;
    o_conv_trig = 1'b0;
  end

  // Idle bus shows inverted data, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == `RRS_ADDR_RR_EN || a == `RRS_ADDR_EDGE)
      v = d & 8'h01;
    @(negedge i_mclk);
    o_wr_valid = 1'b1;
    o_wr = {a, v};
    @(negedge i_mclk);
    o_wr_valid = 1'b0;
    o_wr = ~o_wr;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge i_mclk);
    o_rd_valid = 1'b1;
    o_rd_addr = a;
    @(negedge i_mclk);
    o_rd_valid = 1'b0;
    o_rd_addr = ~a;
  endtask

  task automatic key();
    wr(`RRS_ADDR_KEY, `RRS_KEY_FIRST);
    wr(`RRS_ADDR_KEY, `RRS_KEY_SECOND);
  endtask

  task automatic trig(input logic v);
    @(negedge i_mclk);
    o_conv_trig = v;
    @(negedge i_mclk);
    @(negedge i_mclk);
  endtask
endmodule

// *** verif/testbench.sv ***
/*
  Self-checking bench: eight- and four-channel banks on one host bus.
  Assumes the host model owns every bus input of both banks.
*/
module testbench
  import rrs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic mclk, arst_n, wr_valid, rd_valid, trig, sr8, sr4, rr8, rr4, e;
  rrs_wr_s wr, wr4;
  logic [7:0] rd_addr, d8, d4, m;
  logic [2:0] sel8;
  logic [1:0] sel4;
  logic [31:0] rs;
  int n_fail, n_tests, n_sr, cur, cur4;

  rrs_host_model u_rrs_host_model (.i_mclk(mclk), .o_wr_valid(wr_valid),
    .o_wr(wr), .o_rd_valid(rd_valid), .o_rd_addr(rd_addr),
    .o_conv_trig(trig));

  rrs_cfg_bank #(.NUM_CHAN(8)) u_rrs_cfg_bank (.i_mclk(mclk),
    .i_arst_n(arst_n), .i_wr_valid(wr_valid), .i_wr(wr),
    .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .o_rd_data(d8),
    .i_conv_trig(trig), .o_chan_sel(sel8), .o_rr_active(rr8),
    .o_soft_reset(sr8));

  // reserved mask bits of the four-channel bank are written as zero
  assign wr4 = {wr.addr, (wr.addr == 8'h07) ? (wr.data & 8'h0F) : wr.data};

  // Four-channel variant sees the same traffic
  rrs_cfg_bank #(.NUM_CHAN(4)) u_rrs_cfg_bank4 (.i_mclk(mclk),
    .i_arst_n(arst_n), .i_wr_valid(wr_valid), .i_wr(wr4),
    .i_rd_valid(rd_valid), .i_rd_addr(rd_addr), .o_rd_data(d4),
    .i_conv_trig(trig), .o_chan_sel(sel4), .o_rr_active(rr4),
    .o_soft_reset(sr4));

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(negedge mclk)
    if (sr8 === 1'b1 && sr4 === 1'b1)
      n_sr++;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  function automatic int nxt(input logic [7:0] mk, input int c, input int n);
    for (int i = 1; i <= n; i++)
      if (mk[(c + i) % n])
        return (c + i) % n;
    return c;
  endfunction

  task automatic report_and_stop();
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e8, e4);
    u_rrs_host_model.rd(a);
    chk(d8, e8);
    chk(d4, e4);
  endtask

  task automatic chks();
    chk({5'h00, sel8}, 8'(cur));
    chk({6'h00, sel4}, 8'(cur4));
  endtask

  task automatic step(input logic v);
    u_rrs_host_model.trig(v);
    if (v == e)
    begin
      cur = nxt(m, cur, 8);
      cur4 = nxt(m & 8'h0F, cur4, 4);
    end
  endtask

  initial
  begin
    #(50 * 5000);
    n_fail++;
    report_and_stop();
  end

  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial
  begin
    arst_n = 1'b0;
    n_fail = 0;
    n_tests = 0;
    n_sr = 0;
    rs = 32'h24;
    cur = 0;
    cur4 = 0;
    repeat (5) @(negedge mclk);
    arst_n = 1'b1;
    rdc(8'h06, 8'h00, 8'h00);
    rdc(8'h07, 8'hFF, 8'h0F);
    rdc(8'h09, 8'h00, 8'h00);
    rdc(8'h0B, 8'h00, 8'h00);
    $display("test defaults done");
    u_rrs_host_model.wr(8'h06, 8'h01);
    chk({7'h00, rr8}, 8'h01);
    chk({7'h00, rr4}, 8'h01);
    for (int k = 0; k < 6; k++)
    begin
      rs = xs(rs);
      m = (k == 0) ? 8'h80 : (k == 1) ? 8'h00 : rs[7:0];
      e = rs[8];
      u_rrs_host_model.wr(8'h07, m);
      u_rrs_host_model.wr(8'h09, {7'h00, e});
      rdc(8'h07, m, m & 8'h0F);
      rdc(8'h09, {7'h00, e}, {7'h00, e});
      repeat (4)
      begin
        step(~e);
        chks();
        step(e);
        chks();
      end
    end
    $display("test sequencing done");
    // Full mask so that any wrongly taken edge would move the channel
    u_rrs_host_model.wr(8'h07, 8'hFF);
    u_rrs_host_model.wr(8'h06, 8'h00);
    chk({7'h00, rr4}, 8'h00);
    u_rrs_host_model.trig(~e);
    u_rrs_host_model.trig(e);
    chks();
    m = 8'h55;
    $display("test mode off done");
    u_rrs_host_model.wr(8'h0B, 8'hA3);
    rdc(8'h0B, 8'h00, 8'h00);
    u_rrs_host_model.wr(8'h07, m);
    u_rrs_host_model.wr(8'h0B, 8'h05);
    u_rrs_host_model.wr(8'h0B, 8'hA3);
    u_rrs_host_model.wr(8'h0B, 8'h11);
    u_rrs_host_model.wr(8'h0B, 8'h05);
    chk(8'(n_sr), 8'h00);
    rdc(8'h07, 8'h55, 8'h05);
    u_rrs_host_model.wr(8'h06, 8'h01);
    u_rrs_host_model.wr(8'h09, 8'h01);
    e = 1'b1;
    step(1'b0);
    step(1'b1);
    chks();
    u_rrs_host_model.key();
    repeat (3) @(negedge mclk);
    chk(8'(n_sr), 8'h01);
    rdc(8'h06, 8'h00, 8'h00);
    rdc(8'h07, 8'hFF, 8'h0F);
    rdc(8'h09, 8'h00, 8'h00);
    chk({7'h00, rr8}, 8'h00);
    chk({7'h00, rr4}, 8'h00);
    cur = 0;
    cur4 = 0;
    chks();
    $display("test key done");
    report_and_stop();
  end
endmodule
